// >>> design/cpu_clock_select_control.v
// CPU clock source and divider control with its control registers
// Assumes oscillator clocks arrive as slow pins, sampled on i_ref_clk,
// and that register accesses come from the CPU on i_ref_clk
//
// Operation
// - Main oscillator halts by stop instruction or bit
// - Subsystem oscillator always runs, never stopped
// - Control register holds source, divider, halt, resistor
// - Register accepts single-bit and whole-byte writes
// - Control register resets to 04H
// - Divider codes select fxx/1..16 or fxt/2
// - Status bit 5 read-only, shows running source
// - Bit 6 disconnects subsystem feedback resistor
// - Halt bit 7 stops main oscillator
// - Bypass bit selects fx or fx/2 as fxx
// - Reset: slowest rate, main oscillator stopped
`include "cpu_clock_select_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module cpu_clock_select_control
(
    // Clock and reset
    input  wire        i_ref_clk,
    input  wire        i_srst,
    // Memory manipulation access
    input  wire [15:0] i_mem_addr,
    input  wire        i_mem_byte_wr,
    input  wire        i_mem_bit_wr,
    input  wire [2:0]  i_mem_bit_pos,
    input  wire        i_mem_bit_val,
    input  wire [7:0]  i_mem_wdata,
    output reg  [7:0]  o_mem_rdata,
    // Processor stop instruction
    input  wire        i_stop_mode,
    // Oscillator pins
    input  wire        i_main_oscillator_clock,
    input  wire        i_sub_oscillator_clock,
    // Oscillator controls
    output reg         o_main_osc_halt,
    output reg         o_feedback_resistor_off,
    // Clocks to core and peripherals
    output reg         o_main_sys_clk,
    output reg         o_cpu_clk,
    output reg         o_cpu_clk_rise
);

    reg  [7:0] processor_clock_ctrl;
    reg  [7:0] oscillation_mode_reg;
    reg  [1:0] main_sync;
    reg  [1:0] sub_sync;
    reg        main_prev;
    reg        sub_prev;
    reg        main_half;
    reg        sub_half;
    reg        fxx_prev;
    reg        fxx_byp;
    reg        new_prev;
    reg  [3:0] div_cnt;
    reg        cur_src;
    reg  [2:0] cur_div;
    reg        sw_state;
    reg        cpu_prev;
    reg  [7:0] next_ctrl;
    reg        next_cpu;
    reg        sel_level;
    reg        new_level;
    reg  [2:0] req_div;
    wire       main_rise;
    wire       sub_rise;
    wire       fxx_level;
    wire       fxx_rise;
    wire       pcc_hit;
    wire       osm_hit;
    wire       cpu_src_status;
    wire [`DIV_STAGES:0] tap;

    localparam SW_RUN  = 1'b0;
    localparam SW_HOLD = 1'b1;

    assign pcc_hit = (i_mem_addr == `PROC_CLK_CTRL_ADDR);
    assign osm_hit = (i_mem_addr == `OSC_MODE_ADDR);

    // Pin synchronisers
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            main_sync <= 2'h0;
            sub_sync  <= 2'h0;
        end
        else
        begin
            main_sync <= {main_sync[0], i_main_oscillator_clock};
            sub_sync  <= {sub_sync[0], i_sub_oscillator_clock};
        end
    end

    assign main_rise = main_sync[1] & ~main_prev;
    assign sub_rise  = sub_sync[1] & ~sub_prev;

    // Next control value for byte or bit write
    always @*
    begin
        next_ctrl = processor_clock_ctrl;
        if (i_mem_byte_wr)
            next_ctrl = i_mem_wdata;
        else if (i_mem_bit_wr)
            next_ctrl[i_mem_bit_pos] = i_mem_bit_val;
        next_ctrl = (next_ctrl & `PCC_WRITE_MASK) | (processor_clock_ctrl & ~`PCC_WRITE_MASK);
    end

    // Register writes
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            processor_clock_ctrl <= `PROC_CLK_CTRL_RESET;
            oscillation_mode_reg <= `OSC_MODE_RESET;
        end
        else
        begin
            if (pcc_hit && (i_mem_byte_wr || i_mem_bit_wr))
                processor_clock_ctrl <= next_ctrl;
            if (osm_hit && i_mem_byte_wr)
                oscillation_mode_reg <= i_mem_wdata & `OSM_WRITE_MASK;
        end
    end

    assign cpu_src_status = cur_src;

    // Register read
    always @*
    begin
        o_mem_rdata = 8'h00;
        if (pcc_hit)
        begin
            o_mem_rdata = processor_clock_ctrl;
            o_mem_rdata[`PCC_STATUS_BIT] = cpu_src_status;
            o_mem_rdata[`PCC_RSVD_BIT] = 1'b0;
        end
        else if (osm_hit)
            o_mem_rdata = oscillation_mode_reg;
    end

    // Oscillator controls
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_main_osc_halt         <= 1'b1;
            o_feedback_resistor_off <= 1'b0;
        end
        else
        begin
            o_main_osc_halt         <= i_stop_mode | processor_clock_ctrl[`PCC_HALT_BIT];
            o_feedback_resistor_off <= processor_clock_ctrl[`PCC_FBOFF_BIT];
        end
    end

    // Main system clock and subsystem half-rate clock
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            main_prev <= 1'b0;
            sub_prev  <= 1'b0;
            main_half <= 1'b0;
            sub_half  <= 1'b0;
            fxx_prev  <= 1'b0;
            fxx_byp   <= 1'b0;
        end
        else
        begin
            main_prev <= main_sync[1];
            sub_prev  <= sub_sync[1];
            fxx_prev  <= fxx_level;
            if (main_rise)
                main_half <= ~main_half;
            if (sub_rise)
                sub_half <= ~sub_half;
            // Swap fx and fx/2 only while both are low
            if (!main_sync[1] && !main_half)
                fxx_byp <= oscillation_mode_reg[`OSM_BYPASS_BIT];
        end
    end

    assign fxx_level = fxx_byp ? main_sync[1] : main_half;
    assign fxx_rise  = fxx_level & ~fxx_prev;

    always @(posedge i_ref_clk)
    begin
        if (i_srst)
            o_main_sys_clk <= 1'b0;
        else
            o_main_sys_clk <= fxx_level;
    end

    // Binary divider of fxx
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
            div_cnt <= 4'h0;
        else if (fxx_rise)
            div_cnt <= div_cnt + 4'h1;
    end

    // Divider taps: fxx, fxx/2 .. fxx/16
    assign tap[0] = fxx_level;
    genvar g;
    generate
        for (g = 1; g <= `DIV_STAGES; g = g + 1)
        begin : g_tap
            assign tap[g] = div_cnt[g-1];
        end
    endgenerate

    // Requested setting, prohibited codes clamp to slowest
    always @*
    begin
        req_div = processor_clock_ctrl[`PCC_DIV_MSB:`PCC_DIV_LSB];
        if (req_div > `DIV_CODE_MAX)
            req_div = `DIV_CODE_MAX;
        sel_level = cur_src ? sub_half : tap[cur_div];
        new_level = processor_clock_ctrl[`PCC_SRC_BIT] ? sub_half : tap[req_div];
    end

    // Glitch-free switch sequencer
    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            cur_src  <= 1'b0;
            cur_div  <= `DIV_CODE_MAX;
            sw_state <= SW_RUN;
            cpu_prev <= 1'b0;
            new_prev <= 1'b0;
        end
        else
        begin
            cpu_prev <= sel_level;
            new_prev <= new_level;
            case (sw_state)
                SW_RUN:
                begin
                    if ((processor_clock_ctrl[`PCC_SRC_BIT] != cur_src || req_div != cur_div)
                        && cpu_prev && !sel_level)
                        sw_state <= SW_HOLD;
                end
                SW_HOLD:
                begin
                    // Take the new source at its fall, so its low half is whole
                    if (new_prev && !new_level)
                    begin
                        cur_src  <= processor_clock_ctrl[`PCC_SRC_BIT];
                        cur_div  <= req_div;
                        sw_state <= SW_RUN;
                    end
                end
                default:
                    sw_state <= SW_RUN;
            endcase
        end
    end

    // CPU clock output held low during a switch
    always @*
    begin
        next_cpu = (sw_state == SW_HOLD) ? 1'b0 : sel_level;
    end

    always @(posedge i_ref_clk)
    begin
        if (i_srst)
        begin
            o_cpu_clk      <= 1'b0;
            o_cpu_clk_rise <= 1'b0;
        end
        else
        begin
            o_cpu_clk      <= next_cpu;
            o_cpu_clk_rise <= next_cpu & ~o_cpu_clk;
        end
    end

endmodule

`default_nettype wire

// >>> design/cpu_clock_select_defs.vh
// Constants for the CPU clock select control block
// Included by cpu_clock_select_control.v only
`ifndef CPU_CLOCK_SELECT_DEFS_VH
`define CPU_CLOCK_SELECT_DEFS_VH

// Register addresses
`define PROC_CLK_CTRL_ADDR   16'hfffb
`define OSC_MODE_ADDR        16'hfff9

// Reset values
`define PROC_CLK_CTRL_RESET  8'h04
`define OSC_MODE_RESET       8'h00

// Processor clock control field positions
`define PCC_HALT_BIT         3'h7
`define PCC_FBOFF_BIT        3'h6
`define PCC_STATUS_BIT       3'h5
`define PCC_SRC_BIT          3'h4
`define PCC_RSVD_BIT         3'h3
`define PCC_DIV_MSB          2
`define PCC_DIV_LSB          0

// Writable bit mask (status and reserved bits excluded)
`define PCC_WRITE_MASK       8'hd7

// Oscillation mode field position and mask
`define OSM_BYPASS_BIT       3'h0
`define OSM_WRITE_MASK       8'h01

// Division codes
`define DIV_CODE_MAX         3'h4
`define DIV_STAGES           4

`endif

// >>> tb/cpu_clock_select_control_props.sv
// Port checker for the clock select block
// Assumes a bind into the design top
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_select_control_props
(
    // Observed ports
    input wire logic        i_ref_clk,
    input wire logic        i_srst,
    input wire logic [15:0] i_mem_addr,
    input wire logic        i_mem_byte_wr,
    input wire logic [7:0]  i_mem_wdata,
    input wire logic [7:0]  o_mem_rdata,
    input wire logic        i_stop_mode,
    input wire logic        o_main_osc_halt,
    input wire logic        o_feedback_resistor_off,
    input wire logic        o_main_sys_clk,
    input wire logic        o_cpu_clk
);
    wire logic wr = i_mem_byte_wr && i_mem_addr == 16'hfffb;
    default clocking @(posedge i_ref_clk);
    endclocking
    default disable iff (i_srst);
    reset_out_a: assert property (disable iff (1'b0) i_srst |=> o_main_osc_halt && !o_cpu_clk)
        else $error("reset outputs wrong");
    stop_halt_a: assert property (i_stop_mode |=> o_main_osc_halt) else $error("stop not halting");
    halt_bit_a: assert property (wr && !i_stop_mode ##1 !i_stop_mode
        |=> o_main_osc_halt == $past(i_mem_wdata[7], 2)) else $error("halt bit not applied");
    fb_byte_a: assert property (wr |-> ##2 o_feedback_resistor_off == $past(i_mem_wdata[6], 2))
        else $error("resistor bit not applied");
    sys_high_a: assert property ($rose(o_main_sys_clk) |-> o_main_sys_clk [*3])
        else $error("short system clock high");
    sys_low_a: assert property ($fell(o_main_sys_clk) |-> !o_main_sys_clk [*3])
        else $error("short system clock low");
    rsvd_zero_a: assert property (i_mem_addr == 16'hfffb |-> !o_mem_rdata[3]) else $error("reserved bit set");
    unmapped_a: assert property (!(i_mem_addr inside {16'hfffb, 16'hfff9}) |-> o_mem_rdata == 8'h00)
        else $error("unmapped read not zero");
    clk_high_a: assert property ($rose(o_cpu_clk) |-> o_cpu_clk [*3]) else $error("short high pulse");
    clk_low_a: assert property ($fell(o_cpu_clk) |-> !o_cpu_clk [*3]) else $error("short low pulse");
    cover property (wr && i_mem_wdata[4]);
    cover property (i_stop_mode);
    cover property ($rose(o_cpu_clk));
endmodule
`default_nettype wire

// >>> tb/cpu_clock_select_control_tb_top.sv
// Bench top for the clock select block
// Assumes pin model and checker compiled first
`timescale 1ns/1ps
`default_nettype none
module cpu_clock_select_control_tb_top;
    logic        clk, srst, bwr, btw, bval, stop, mo, so, halt, fb, cc, ccr;
    logic [15:0] addr;
    logic [7:0]  wd, rd, d;
    logic [2:0]  pos;
    int          fails = 0, num_checks = 0, n;
    integer      seed = 62;
    cpu_clock_select_control i_cpu_clock_select_control (.i_ref_clk(clk), .i_srst(srst), .i_mem_addr(addr),
        .i_mem_byte_wr(bwr), .i_mem_bit_wr(btw), .i_mem_bit_pos(pos), .i_mem_bit_val(bval), .i_mem_wdata(wd),
        .o_mem_rdata(rd), .i_stop_mode(stop), .i_main_oscillator_clock(mo), .i_sub_oscillator_clock(so),
        .o_main_osc_halt(halt), .o_feedback_resistor_off(fb), .o_main_sys_clk(), .o_cpu_clk(cc),
        .o_cpu_clk_rise(ccr));
    osc_pins_model i_osc_pins_model (.i_ref_clk(clk), .i_halt(halt), .o_main(mo), .o_sub(so));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = !clk;
    end
    task automatic print_verdict;
        if (fails == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic check(input logic [15:0] s, input logic [15:0] e);
        num_checks++;
        if (s !== e)
        begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] v);
        @(negedge clk);
        addr = a;
        wd = v;
        bwr = 1'b1;
        @(negedge clk);
        bwr = 1'b0;
    endtask
    task automatic bw(input logic [2:0] p, input logic v);
        @(negedge clk);
        addr = 16'hfffb;
        pos = p;
        bval = v;
        btw = 1'b1;
        @(negedge clk);
        btw = 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [7:0] e);
        @(negedge clk);
        addr = a;
        #1 check(rd, e);
    endtask
    task automatic per(input int e);
        repeat (3)
        begin
            n = 0;
            do
            begin
                @(negedge clk);
                n++;
            end
            while (ccr !== 1'b1 && n < 700);
            if (n == 700)
            begin
                fails++;
                print_verdict();
            end
        end
        check(n[15:0], e[15:0]);
    endtask
    function automatic int exp_per(input logic byp, input logic [2:0] c);
        return 8 << (c + !byp);
    endfunction
    initial
    begin
        {srst, bwr, btw, bval, stop, addr, wd, pos} = {5'h10, 27'h0};
        repeat (4) @(posedge clk);
        @(negedge clk);
        check(halt, 1'b1);
        srst = 1'b0;
        rdc(16'hfffb, 8'h04);
        rdc(16'hfff9, 8'h00);
        wr(16'h8000, 8'hff);
        rdc(16'h8000, 8'h00);
        wr(16'hfff9, 8'hff);
        rdc(16'hfff9, 8'h01);
        bw(3'h6, 1'b1);
        bw(3'h5, 1'b1);
        rdc(16'hfffb, 8'h44);
        check(fb, 1'b1);
        repeat (6)
        begin
            d = $random(seed) & 8'hc7;
            if (d[2])
                d[1:0] = 2'h0;
            wr(16'hfffb, d | 8'h20);
            rdc(16'hfffb, d);
            check({halt, fb}, d[7:6]);
        end
        for (int b = 0; b < 2; b++)
            for (int c = 0; c < 5; c++)
            begin
                wr(16'hfff9, 8'(b));
                wr(16'hfffb, 8'(c));
                per(exp_per(b[0], 3'(c)));
            end
        wr(16'hfffb, 8'h10);
        per(80);
        wr(16'hfffb, 8'h90);
        rdc(16'hfffb, 8'hb0);
        check(halt, 1'b1);
        per(80);
        wr(16'hfffb, 8'h10);
        stop = 1'b1;
        @(negedge clk);
        check(halt, 1'b1);
        stop = 1'b0;
        wr(16'hfffb, 8'h04);
        per(128);
        rdc(16'hfffb, 8'h04);
        print_verdict();
    end
endmodule
bind cpu_clock_select_control cpu_clock_select_control_props i_cpu_clock_select_control_props (
    .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_mem_addr(i_mem_addr), .i_mem_byte_wr(i_mem_byte_wr),
    .i_mem_wdata(i_mem_wdata), .o_mem_rdata(o_mem_rdata), .i_stop_mode(i_stop_mode),
    .o_main_osc_halt(o_main_osc_halt), .o_feedback_resistor_off(o_feedback_resistor_off),
    .o_main_sys_clk(o_main_sys_clk), .o_cpu_clk(o_cpu_clk));
`default_nettype wire

// >>> tb/osc_pins_model.sv
// Oscillator pin model: main and sub pins
// Assumes a 200 MHz reference clock
`timescale 1ns/1ps
`default_nettype none
module osc_pins_model
(
    // Reference and halt control
    input  wire logic i_ref_clk,
    input  wire logic i_halt,
    // Oscillator pins
    output wire logic o_main,
    output wire logic o_sub
);
    logic [4:0] cnt = 5'h00;
    logic       mr  = 1'b0;
    logic       sr  = 1'b0;
    assign o_main = mr;
    assign o_sub = sr;
    always @(posedge i_ref_clk)
    begin
        cnt <= (cnt == 5'h13) ? 5'h00 : cnt + 5'h01;
        if (!i_halt && cnt[1:0] == 2'h3)
            mr <= !mr;
        if (cnt == 5'h13)
            sr <= !sr;
    end
endmodule
`default_nettype wire
